// *** design/alarm_cfg.svh ***
// constants for the process alarm comparator: codes, register map, reset values
// ****************************************************************************
// ****************************************************************************
`ifndef ALARM_CFG_SVH
`define ALARM_CFG_SVH

`define ALM_CHANNELS     4
`define ALM_DATA_W       16

// ****************************************************************************
// alarm type codes
// ****************************************************************************
`define ALM_OFF          5'h00
`define ALM_UPLO         5'h01
`define ALM_DEV_UP       5'h02
`define ALM_DEV_LO       5'h03
`define ALM_RANGE        5'h04
`define ALM_UPLO_SB      5'h05
`define ALM_DEV_UP_SB    5'h06
`define ALM_DEV_LO_SB    5'h07
`define ALM_ABS_UP       5'h08
`define ALM_ABS_LO       5'h09
`define ALM_ABS_UP_SB    5'h0a
`define ALM_ABS_LO_SB    5'h0b
`define ALM_LOOP_BREAK   5'h0c
`define ALM_RATE         5'h0d
`define ALM_SP_UP        5'h0e
`define ALM_SP_LO        5'h0f
`define ALM_MV_UP        5'h10
`define ALM_MV_LO        5'h11

// ****************************************************************************
// register map (byte addresses, channel address fields, ctrl bit positions)
// ****************************************************************************
`define REG_CTRL         8'h00
`define REG_ALARM        8'h04
`define REG_IRQ_STATUS   8'h08
`define REG_IRQ_MASK     8'h0c
`define REG_CH_BASE_HI   2'h1
`define CH_TYPE          2'h0
`define CH_VALUE         2'h1
`define CH_LOWER         2'h2
`define CH_HYST          2'h3

`define CTRL_HEAT_COOL   0
`define CTRL_RESTART     1
`define CTRL_ASSIGN_LSB  4

// ****************************************************************************
// reset values
// ****************************************************************************
`define RST_TYPE         5'h02
`define RST_ASSIGN       4'hf
`define RST_HYST         16'h0002

`endif

// *** design/alarm_pkg.sv ***
// types shared by the process alarm comparator
package alarm_pkg;

  typedef logic [4:0] alarm_code_t;

  typedef enum logic [1:0] {
    RESP_OKAY   = 2'b00,
    RESP_SLVERR = 2'b10
  } axi_resp_t;

endpackage

// *** design/process_alarm_comparator.sv ***
// four-channel process alarm comparator with an axi4-lite register slave
`timescale 1ns/1ps
`include "alarm_cfg.svh"

module process_alarm_comparator
  import alarm_pkg::*;
#(
  parameter int CHANNELS = `ALM_CHANNELS,
  parameter int DATA_W   = `ALM_DATA_W
) (
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire logic signed [DATA_W-1:0] process_value,
  input  wire logic signed [DATA_W-1:0] set_point,
  input  wire logic signed [DATA_W-1:0] manipulated_variable,
  input  wire logic signed [DATA_W-1:0] manipulated_variable_cool,
  input  wire logic [7:0]               awaddr,
  input  wire logic [2:0]               awprot,
  input  wire logic                     awvalid,
  output logic                          awready,
  input  wire logic [31:0]              wdata,
  input  wire logic [3:0]               wstrb,
  input  wire logic                     wvalid,
  output logic                          wready,
  output logic [1:0]                    bresp,
  output logic                          bvalid,
  input  wire logic                     bready,
  input  wire logic [7:0]               araddr,
  input  wire logic [2:0]               arprot,
  input  wire logic                     arvalid,
  output logic                          arready,
  output logic [31:0]                   rdata,
  output logic [1:0]                    rresp,
  output logic                          rvalid,
  input  wire logic                     rready,
  output logic [CHANNELS-1:0]           alarm_out,
  output logic                          irq
);

  localparam int EW = DATA_W + 2;

  function automatic logic signed [EW-1:0] sx(input logic signed [DATA_W-1:0] v);
    return {{2{v[DATA_W-1]}}, v};
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // ****************************************************************************
  // configuration and status storage
  // ****************************************************************************
  alarm_code_t               alarm_type      [CHANNELS];
  logic signed [DATA_W-1:0]  alarm_value     [CHANNELS];
  logic signed [DATA_W-1:0]  alarm_lower     [CHANNELS];
  logic [DATA_W-1:0]         alarm_hysteresis[CHANNELS];
  logic [CHANNELS-1:0]       type_written;
  logic                      heat_cool;
  logic [CHANNELS-1:0]       assigned;
  logic                      restart;
  logic [CHANNELS-1:0]       irq_status;
  logic [CHANNELS-1:0]       irq_mask;
  logic [CHANNELS-1:0]       alarm_rise;

  // ****************************************************************************
  // axi4-lite write channel
  // ****************************************************************************
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        aw_held, w_held, wr_fire, wr_ok;
  logic [1:0]  wr_ch;
  logic [1:0]  wr_field;
  logic [31:0] wr_val;

  assign awready  = !aw_held && !bvalid;
  assign wready   = !w_held && !bvalid;
  assign wr_fire  = aw_held && w_held && !bvalid;
  assign wr_ch    = aw_addr[5:4];
  assign wr_field = aw_addr[3:2];
  assign wr_val   = merge({24'h000000, assigned, 2'b00, 1'b0, heat_cool}, w_data, w_strb);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
      w_held  <= 1'b0;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
      bvalid  <= 1'b0;
      bresp   <= RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_held <= 1'b1;
        aw_addr <= awaddr;
      end
      if (wvalid && wready) begin
        w_held <= 1'b1;
        w_data <= wdata;
        w_strb <= wstrb;
      end
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held  <= 1'b0;
        bvalid  <= 1'b1;
        bresp   <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_comb begin
    wr_ok = 1'b1;
    if (aw_addr[7:6] != `REG_CH_BASE_HI) begin
      wr_ok = (aw_addr == `REG_CTRL) || (aw_addr == `REG_IRQ_STATUS) ||
              (aw_addr == `REG_IRQ_MASK);
    end else if (int'(wr_ch) >= CHANNELS || aw_addr[1:0] != 2'b00) begin
      wr_ok = 1'b0;
    end
  end

  // ****************************************************************************
  // register writes
  // ****************************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      heat_cool <= 1'b0;
      assigned  <= `RST_ASSIGN;
      restart   <= 1'b1;
      irq_mask  <= '0;
    end else begin
      restart <= 1'b0;
      if (wr_fire && wr_ok && aw_addr == `REG_CTRL) begin
        heat_cool <= wr_val[`CTRL_HEAT_COOL];
        restart   <= wr_val[`CTRL_RESTART];
        assigned  <= wr_val[`CTRL_ASSIGN_LSB +: CHANNELS];
      end
      if (wr_fire && wr_ok && aw_addr == `REG_IRQ_MASK && w_strb[0]) begin
        irq_mask <= w_data[CHANNELS-1:0];
      end
    end
  end

  // set wins over a simultaneous write-one-to-clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_status <= '0;
    end else begin
      irq_status <= (irq_status &
                     ~((wr_fire && wr_ok && aw_addr == `REG_IRQ_STATUS && w_strb[0]) ?
                       w_data[CHANNELS-1:0] : '0)) | alarm_rise;
    end
  end

  assign irq = |(irq_status & irq_mask);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int c = 0; c < CHANNELS; c++) begin
        alarm_type[c]       <= `RST_TYPE;
        alarm_value[c]      <= '0;
        alarm_lower[c]      <= '0;
        alarm_hysteresis[c] <= `RST_HYST;
      end
      type_written <= '0;
    end else begin
      type_written <= '0;
      if (wr_fire && wr_ok && aw_addr[7:6] == `REG_CH_BASE_HI) begin
        case (wr_field)
          `CH_TYPE: begin
            // unknown codes and a loop-break request off channel 0 keep the old type
            if (w_strb[0] && w_data[7:0] <= 8'(`ALM_MV_LO) &&
                !(w_data[4:0] == `ALM_LOOP_BREAK && wr_ch != 2'h0)) begin
              alarm_type[wr_ch]   <= w_data[4:0];
              type_written[wr_ch] <= 1'b1;
            end
          end
          `CH_VALUE: begin
            alarm_value[wr_ch] <= DATA_W'(merge(32'(alarm_value[wr_ch]), w_data, w_strb));
          end
          `CH_LOWER: begin
            alarm_lower[wr_ch] <= DATA_W'(merge(32'(alarm_lower[wr_ch]), w_data, w_strb));
          end
          default: begin
            alarm_hysteresis[wr_ch] <=
              DATA_W'(merge(32'(alarm_hysteresis[wr_ch]), w_data, w_strb));
          end
        endcase
      end
    end
  end

  // ****************************************************************************
  // axi4-lite read channel
  // ****************************************************************************
  logic [31:0] rd_data;
  logic        rd_ok;

  assign arready = !rvalid;

  always_comb begin
    rd_data = 32'h0000_0000;
    rd_ok   = 1'b1;
    if (araddr[7:6] == `REG_CH_BASE_HI && int'(araddr[5:4]) < CHANNELS &&
        araddr[1:0] == 2'b00) begin
      case (araddr[3:2])
        `CH_TYPE:  rd_data = 32'(alarm_type[araddr[5:4]]);
        `CH_VALUE: rd_data = 32'($unsigned(alarm_value[araddr[5:4]]));
        `CH_LOWER: rd_data = 32'($unsigned(alarm_lower[araddr[5:4]]));
        default:   rd_data = 32'(alarm_hysteresis[araddr[5:4]]);
      endcase
    end else begin
      case (araddr)
        `REG_CTRL:       rd_data = {24'h000000, assigned, 3'b000, heat_cool};
        `REG_ALARM:      rd_data = 32'(alarm_out);
        `REG_IRQ_STATUS: rd_data = 32'(irq_status);
        `REG_IRQ_MASK:   rd_data = 32'(irq_mask);
        default:         rd_ok = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata  <= rd_data;
      rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

  // ****************************************************************************
  // per-channel alarm evaluation
  // ****************************************************************************
  for (genvar c = 0; c < CHANNELS; c++) begin : g_ch
    alarm_code_t           code;
    logic signed [EW-1:0]  q_up, q_lo, thr_up, thr_lo, hy;
    logic                  pair, sb_code, up_st, lo_st, next_up, next_lo;
    logic                  raw, overlap, standby, live, gate;

    assign code = alarm_type[c];

    always_comb begin
      pair    = code == `ALM_UPLO || code == `ALM_RANGE || code == `ALM_UPLO_SB;
      sb_code = code == `ALM_UPLO_SB || code == `ALM_DEV_UP_SB || code == `ALM_DEV_LO_SB ||
                code == `ALM_ABS_UP_SB || code == `ALM_ABS_LO_SB;
      live    = assigned[c] && code != `ALM_OFF && code != `ALM_LOOP_BREAK &&
                code != `ALM_RATE;
      // a dead channel must not carry hysteresis into a later reassignment
      hy      = live ? EW'(alarm_hysteresis[c]) : '0;
      q_up    = sx(process_value);
      q_lo    = sx(process_value);
      if (code == `ALM_SP_UP) begin
        q_up = sx(set_point);
      end else if (code == `ALM_MV_UP) begin
        q_up = sx(manipulated_variable);
      end
      if (code == `ALM_SP_LO) begin
        q_lo = sx(set_point);
      end else if (code == `ALM_MV_LO) begin
        q_lo = heat_cool ? sx(manipulated_variable_cool) : sx(manipulated_variable);
      end
      thr_up = sx(alarm_value[c]);
      thr_lo = sx(alarm_value[c]);
      if (pair) begin
        thr_up = sx(set_point) + sx(alarm_value[c]);
        thr_lo = sx(set_point) - sx(alarm_lower[c]);
      end else if (code == `ALM_DEV_UP || code == `ALM_DEV_UP_SB) begin
        thr_up = sx(set_point) + sx(alarm_value[c]);
      end else if (code == `ALM_DEV_LO || code == `ALM_DEV_LO_SB) begin
        thr_lo = sx(set_point) - sx(alarm_value[c]);
      end
      // once on, a limit releases only past threshold by the hysteresis
      next_up = up_st ? (q_up > thr_up - hy) : (q_up > thr_up);
      next_lo = lo_st ? (q_lo < thr_lo + hy) : (q_lo < thr_lo);
      overlap = (thr_up - hy) <= (thr_lo + hy);
      case (code)
        `ALM_UPLO, `ALM_UPLO_SB:                       raw = next_up || next_lo;
        `ALM_RANGE:                                    raw = !next_up && !next_lo;
        `ALM_DEV_UP, `ALM_DEV_UP_SB, `ALM_ABS_UP, `ALM_ABS_UP_SB,
        `ALM_SP_UP, `ALM_MV_UP:                        raw = next_up;
        `ALM_DEV_LO, `ALM_DEV_LO_SB, `ALM_ABS_LO, `ALM_ABS_LO_SB,
        `ALM_SP_LO, `ALM_MV_LO:                        raw = next_lo;
        default:                                       raw = 1'b0;
      endcase
      // a restart or type write blocks at once, not one edge later when standby rearms
      gate = live && raw && !(sb_code && (standby || restart || type_written[c])) &&
             !(code == `ALM_UPLO_SB && overlap);
    end

    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        up_st <= 1'b0;
        lo_st <= 1'b0;
      end else begin
        up_st <= next_up;
        lo_st <= next_lo;
      end
    end

    // standby rearms on reset, on a restart request and on a new type
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        standby <= 1'b1;
      end else if (restart || type_written[c]) begin
        standby <= 1'b1;
      end else if (!raw) begin
        standby <= 1'b0;
      end
    end

    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        alarm_out[c]  <= 1'b0;
        alarm_rise[c] <= 1'b0;
      end else begin
        alarm_out[c]  <= gate;
        alarm_rise[c] <= !alarm_out[c] && gate;
      end
    end
  end

endmodule

// *** dv/alarm_checker.sv ***
// bus handshake assertions on the ports of the process alarm comparator
`timescale 1ns/1ps
module alarm_checker (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic [1:0]  bresp,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  rresp,
  input wire logic        rvalid,
  input wire logic        rready
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // ****************************************************************
  // write channel
  // ****************************************************************
  sequence wr_taken;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence b_answer;
    ##[1:2] bvalid;
  endsequence
  chk_write_answer: assert property (wr_taken |-> b_answer)
    else $error("write response missing");
  chk_bvalid_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  chk_b_release: assert property (bvalid && bready |=> !bvalid)
    else $error("write response repeated");
  chk_aw_block: assert property (bvalid |-> !awready && !wready)
    else $error("write accepted while response pending");
  chk_bresp_code: assert property (bvalid |-> bresp inside {2'b00, 2'b10})
    else $error("illegal write response code");
  // ****************************************************************
  // read channel
  // ****************************************************************
  chk_read_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read data late");
  chk_rvalid_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata)
                                    && $stable(rresp))
    else $error("read data changed while waiting");
  chk_ar_block: assert property (arready == !rvalid)
    else $error("read address ready wrong");
  chk_slverr_data: assert property (rvalid && rresp == 2'b10 |-> rdata == 32'h0)
    else $error("error read returned data");
endmodule

bind process_alarm_comparator alarm_checker chk_inst (
  .clk, .rst_n, .awvalid, .awready, .wvalid, .wready, .bresp, .bvalid, .bready,
  .arvalid, .arready, .rdata, .rresp, .rvalid, .rready
);

// *** dv/test_process_alarm_comparator.sv ***
// self-checking bench for the process alarm comparator
`timescale 1ns/1ps
`include "alarm_cfg.svh"
module test_process_alarm_comparator
  import alarm_pkg::*;
;
  logic               clk = 0;
  logic               rst_n = 0;
  logic signed [15:0] meas = 0, target = 0, heat = 0, cool = 0;
  logic [7:0]         awaddr = 0, araddr = 0;
  logic [2:0]         awprot = 0, arprot = 0;
  logic [31:0]        wdata = 0;
  logic [3:0]         wstrb = 4'hf;
  logic               awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  wire logic          awready, wready, bvalid, arready, rvalid, irq;
  wire logic [1:0]    bresp, rresp;
  wire logic [31:0]   rdata;
  wire logic [3:0]    alarm_out;
  int                 err_total = 0, check_count = 0;
  logic [33:0]        qr[$];
  logic [1:0]         qb[$];

  process_alarm_comparator process_alarm_comparator_inst (
    .clk, .rst_n, .process_value(meas), .set_point(target),
    .manipulated_variable(heat), .manipulated_variable_cool(cool),
    .awaddr, .awprot, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arprot, .arvalid, .arready,
    .rdata, .rresp, .rvalid, .rready, .alarm_out, .irq
  );

  initial forever #50 clk = ~clk;
  // ****************************************************************
  // checking and closing
  // ****************************************************************
  task automatic check(input string n, input logic [33:0] s, input logic [33:0] e);
    check_count++;
    if (s !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // the monitor sees pre-edge values, so it pairs with the handshake edge
  always @(posedge clk) begin
    if (rvalid === 1'b1 && rready === 1'b1) check("read", {rresp, rdata}, qr.pop_front());
    if (bvalid === 1'b1 && bready === 1'b1) check("bresp", {32'h0, bresp}, {32'h0, qb.pop_front()});
  end
  // ****************************************************************
  // bus master
  // ****************************************************************
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e = RESP_OKAY);
    logic ta, tw, tb;
    qb.push_back(e);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
      @(negedge clk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid && bready;
      @(posedge clk);
      if (ta) awvalid <= 0;
      if (tw) wvalid <= 0;
    end while (!tb);
    bready <= 0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e = RESP_OKAY);
    logic ta, tr;
    qr.push_back({e, d});
    @(posedge clk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do begin
      @(negedge clk);
      ta = arvalid && arready;
      tr = rvalid && rready;
      @(posedge clk);
      if (ta) arvalid <= 0;
    end while (!tr);
    rready <= 0;
  endtask

  function automatic logic [7:0] ch(input int n, input int off);
    return 8'h40 + 8'(16 * n) + 8'(off);
  endfunction

  // type goes last so that a standby type arms with its limits in place
  task automatic cfg(input int n, input logic [4:0] code, input int x, lo, hy);
    wr(ch(n, 12), 32'(hy));
    wr(ch(n, 4), 32'(x));
    wr(ch(n, 8), 32'(lo));
    wr(ch(n, 0), {27'h0, code});
  endtask

  // alarm follows the inputs one edge later; three edges leave margin
  task automatic drv(input int m, t, h, c, input logic [3:0] e);
    @(posedge clk);
    meas <= 16'(m);
    target <= 16'(t);
    heat <= 16'(h);
    cool <= 16'(c);
    repeat (3) @(posedge clk);
    @(negedge clk);
    check("alarm_out", {30'h0, alarm_out}, {30'h0, e});
    rd(`REG_ALARM, {28'h0, e});
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  initial begin
    void'($urandom(89));
    repeat (3) @(posedge clk);
    rst_n <= 1;
    rd(`REG_CTRL, 32'hf0);
    rd(ch(1, 0), 32'h2);
    rd(ch(1, 12), 32'h2);
    rd(`REG_IRQ_MASK, 32'h0);
    for (int n = 1; n < 4; n++) wr(ch(n, 0), 32'h0);
    cfg(0, `ALM_ABS_LO, 100, 0, 0);
    drv(60 + int'($urandom % 39), 0, 0, 0, 4'h1);
    drv(150, 0, 0, 0, 4'h0);
    wr(ch(0, 0), 32'(`ALM_SP_UP));
    drv(0, 101 + int'($urandom % 99), 0, 0, 4'h1);
    drv(0, 100, 0, 0, 4'h0);
    wr(ch(0, 0), 32'(`ALM_SP_LO));
    drv(0, 50, 0, 0, 4'h1);
    wr(ch(0, 0), 32'(`ALM_MV_UP));
    drv(0, 0, 150, 0, 4'h1);
    wr(ch(0, 0), 32'(`ALM_MV_LO));
    drv(0, 0, 50, 150, 4'h1);
    wr(`REG_CTRL, 32'hf1);
    drv(0, 0, 50, 150, 4'h0);
    drv(0, 0, 150, 50, 4'h1);
    wr(ch(0, 0), 32'(`ALM_MV_UP));
    drv(0, 0, 50, 150, 4'h0);
    wr(`REG_CTRL, 32'hf0);
    wr(ch(1, 0), 32'(`ALM_LOOP_BREAK));
    rd(ch(1, 0), 32'h0);
    wr(ch(0, 0), 32'(`ALM_LOOP_BREAK));
    rd(ch(0, 0), 32'hc);
    wr(ch(0, 0), 32'h12);
    rd(ch(0, 0), 32'hc);
    cfg(2, `ALM_ABS_UP, 100, 0, 10);
    cfg(1, `ALM_ABS_UP, 100, 0, 0);
    drv(101, 0, 0, 0, 4'h6);
    drv(95, 0, 0, 0, 4'h4);
    drv(90, 0, 0, 0, 4'h0);
    wr(ch(1, 0), 32'h0);
    // standby only holds while the quantity is already in the alarm region
    drv(200, 0, 0, 0, 4'h4);
    wr(ch(2, 0), 32'(`ALM_ABS_UP_SB));
    rd(`REG_ALARM, 32'h0);
    drv(50, 0, 0, 0, 4'h0);
    drv(200, 0, 0, 0, 4'h4);
    wr(ch(2, 0), 32'h0);
    cfg(3, `ALM_UPLO, 5, 50, 0);
    drv(-20, 0, 0, 0, 4'h0);
    drv(10, 0, 0, 0, 4'h8);
    wr(`REG_CTRL, 32'h70);
    drv(10, 0, 0, 0, 4'h0);
    wr(`REG_CTRL, 32'hf0);
    cfg(3, `ALM_UPLO_SB, 5, 50, 30);
    drv(1000, 0, 0, 0, 4'h0);
    drv(-1000, 0, 0, 0, 4'h0);
    wr(ch(3, 12), 32'h1);
    drv(0, 0, 0, 0, 4'h0);
    drv(1000, 0, 0, 0, 4'h8);
    rd(`REG_IRQ_STATUS, 32'hf);
    wr(`REG_IRQ_STATUS, 32'hf);
    rd(`REG_IRQ_STATUS, 32'h0);
    wr(`REG_IRQ_MASK, 32'h8);
    drv(0, 0, 0, 0, 4'h0);
    drv(1000, 0, 0, 0, 4'h8);
    check("irq", {33'h0, irq}, 34'h1);
    wr(`REG_IRQ_MASK, 32'h0);
    check("irq", {33'h0, irq}, 34'h0);
    wr(`REG_IRQ_MASK, 32'h8);
    wr(`REG_IRQ_STATUS, 32'h8);
    check("irq", {33'h0, irq}, 34'h0);
    rd(8'h20, 32'h0, RESP_SLVERR);
    wr(8'h41, 32'h1, RESP_SLVERR);
    stop_test();
  end

  // about 80 bus operations of a few cycles each fit well inside this span
  initial begin
    #(100 * 20000);
    err_total++;
    stop_test();
  end
endmodule
